// [rtl/pdps_pkg.sv]
package pdps_pkg;
  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int DB_PERIOD_S = 10;
  localparam int DB_PERIOD_MS = DB_PERIOD_S * 1000;
  localparam int DB_PULSE_MS_RST = 100;
  // Bus monitor scale, one code step in millivolts
  localparam int BUS_VOLTAGE_MONITOR_W = 10;
  localparam int BUS_VOLTAGE_MONITOR_LSB_MV = 25;
  localparam int VBUS_MIN_MV = 4500;
  localparam int VBUS_MAX_MV = 22000; // 20 V plus ten percent
  localparam int VSAFE5_MV = 5000;
  localparam int VPRESENT_MV = 800;
  localparam logic [9:0] VBUS_MIN_CODE = 10'(VBUS_MIN_MV / BUS_VOLTAGE_MONITOR_LSB_MV);
  localparam logic [9:0] VBUS_MAX_CODE = 10'(VBUS_MAX_MV / BUS_VOLTAGE_MONITOR_LSB_MV);
  localparam logic [9:0] VSAFE5_CODE = 10'(VSAFE5_MV / BUS_VOLTAGE_MONITOR_LSB_MV);
  localparam logic [9:0] VPRESENT_CODE = 10'(VPRESENT_MV / BUS_VOLTAGE_MONITOR_LSB_MV);
  localparam logic [6:0] PCT_FULL = 7'h64;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLEED = 8'h04;
  localparam logic [7:0] OFS_DBPW = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  // Control fields
  localparam int CTRL_UFP = 0;
  localparam int CTRL_PROVIDER = 1;
  localparam int CTRL_CONTRACT = 2;
  localparam int CTRL_SWAP = 3;
  localparam int CTRL_SRC_REQ = 4;
  localparam int CTRL_BLEED_GO = 5; // Write one to start, reads zero
  localparam int CTRL_STARTUP_CLR = 6; // Write one to clear the flag
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Bleed fields: destination code and release percentage
  localparam int BLEED_DEST_LSB = 0;
  localparam int BLEED_PCT_LSB = 16;
  localparam logic [9:0] BLEED_DEST_RST = VSAFE5_CODE;
  localparam logic [6:0] BLEED_PCT_RST = 7'h5A;
  // Status fields
  localparam int ST_BLEED = 0;
  localparam int ST_KEEP = 1;
  localparam int ST_ID = 2;
  localparam int ST_EMU = 3;
  localparam int ST_DB = 4;
  localparam int ST_SRC = 5;
  localparam int ST_EPWR = 6;
  localparam int ST_SWAP_OK = 7;
  localparam int ST_STARTUP_DONE = 8;
  localparam int ST_VPRES = 9;
  localparam int ST_BUS_VOLTAGE_MONITOR_LSB = 16;
  typedef enum logic [0:0] {BLEED_IDLE, BLEED_ACTIVE} pdps_bleed_e;
endpackage : pdps_pkg

// [rtl/pdps_sync.sv]
`timescale 1ns/10ps
// Two-stage synchroniser, one chain per bit
module pdps_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);
  // Both stages hold the input relative to its idle level, so a plain zero reset
  // still presents the idle level and no false edge follows reset
  logic [W-1:0] meta;
  logic [W-1:0] hold;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i] <= 1'b0;
          hold[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i] ^ rst_val[i];
          hold[i] <= meta[i];
        end
      end
      assign sync_out[i] = hold[i] ^ rst_val[i];
    end
  endgenerate
endmodule : pdps_sync

// [rtl/pdps_top.sv]
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
module pdps_top import pdps_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DB_PERIOD_TICKS = DB_PERIOD_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [BUS_VOLTAGE_MONITOR_W-1:0] bus_voltage_monitor,
  input wire logic insertion_detect_n,
  input wire logic micro_a_plug_present,
  input wire logic external_supply_present,
  output logic bus_bleed_drive,
  output logic upstream_keep_connected,
  output logic id_plug_indicator,
  output logic charger_emulation_enable,
  output logic dead_battery_supply_enable,
  output logic vbus_source_enable,
  output logic pdo_externally_powered,
  output logic role_swap_accept
);
  logic [2:0] pin_s;
  logic ins_n_s;
  logic plug_s;
  logic ext_s;
  logic [31:0] ctrl;
  logic [9:0] dest;
  logic [6:0] pct;
  logic [15:0] db_pw;
  logic startup_done;
  pdps_bleed_e bleed_st;
  logic [31:0] stat;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic in_range;
  logic vbus_present;
  logic at_thresh;
  logic bleed_go;
  logic [16:0] bus_voltage_monitor_scaled;
  logic [16:0] thresh_scaled;
  logic [15:0] tick_cnt;
  logic tick;
  logic [15:0] period_cnt;
  logic [15:0] pulse_cnt;

  // Pin inputs cross into pclk; insertion sense idles high like its pull-up
  pdps_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({insertion_detect_n, micro_a_plug_present, external_supply_present}),
    .rst_val(3'b100),
    .sync_out(pin_s)
  );
  // Bit order of the chain: insertion, plug, external supply
  assign ins_n_s = pin_s[2];
  assign plug_s = pin_s[1];
  assign ext_s = pin_s[0];

  // APB decode; no wait state, read data leave a flop loaded in the setup cycle
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_BLEED) ||
                  (paddr == OFS_DBPW) || (paddr == OFS_STAT);
  assign wr_acc = psel && penable && pwrite && mapped;
  // Setup cycle is where read data are captured
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;
  assign bleed_go = wr_acc && (paddr == OFS_CTRL) && pwdata[CTRL_BLEED_GO];

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      // Holes in the map answer with an error and zero data
      pslverr <= !mapped;
      prdata <= 32'h0000_0000;
      // Status is taken one cycle before the master reads it; that lag is harmless
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL: prdata <= ctrl;
          OFS_BLEED: prdata <= {9'h000, pct, 6'h00, dest};
          OFS_DBPW: prdata <= {16'h0000, db_pw};
          OFS_STAT: prdata <= stat;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; the go bit is a strobe and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (wr_acc && paddr == OFS_CTRL) begin
      ctrl <= {27'h0000000, pwdata[CTRL_SRC_REQ:CTRL_UFP]};
    end
  end

  // Destination, release percentage and pulse width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest <= BLEED_DEST_RST;
      pct <= BLEED_PCT_RST;
      db_pw <= 16'(DB_PULSE_MS_RST);
    end else if (wr_acc && paddr == OFS_BLEED) begin
      dest <= pwdata[BLEED_DEST_LSB +: 10];
      pct <= (pwdata[BLEED_PCT_LSB +: 7] > PCT_FULL) ? PCT_FULL : pwdata[BLEED_PCT_LSB +: 7];
    end else if (wr_acc && paddr == OFS_DBPW) begin
      db_pw <= pwdata[15:0];
    end
  end

  // Bus level compares on the monitor code
  assign in_range = (bus_voltage_monitor >= VBUS_MIN_CODE) &&
                    (bus_voltage_monitor <= VBUS_MAX_CODE);
  // Low presence threshold, so a decaying bus still counts as present
  assign vbus_present = bus_voltage_monitor >= VPRESENT_CODE;
  // Percent compare done by cross-multiplying, avoiding a divider
  assign bus_voltage_monitor_scaled = 17'(bus_voltage_monitor) * 17'(PCT_FULL);
  assign thresh_scaled = 17'(dest) * 17'(pct);
  // Equality counts as reached, so release lands on the threshold itself
  assign at_thresh = bus_voltage_monitor_scaled <= thresh_scaled;

  // Bleed sequence: runs only when the target lies below the present level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bleed_st <= BLEED_IDLE;
    end else begin
      case (bleed_st)
        BLEED_IDLE: begin
          if (bleed_go && !at_thresh) begin
            bleed_st <= BLEED_ACTIVE;
          end
        end
        BLEED_ACTIVE: begin
          if (at_thresh) begin
            bleed_st <= BLEED_IDLE;
          end
        end
        default: bleed_st <= BLEED_IDLE;
      endcase
    end
  end

  // Startup flag: insertion sets it and wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_done <= 1'b0;
    end else if (!ins_n_s) begin
      startup_done <= 1'b1;
    end else if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_STARTUP_CLR]) begin
      startup_done <= 1'b0;
    end
  end

  // Pin outputs, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_bleed_drive <= 1'b0;
      upstream_keep_connected <= 1'b0;
      id_plug_indicator <= 1'b1;
      charger_emulation_enable <= 1'b0;
      vbus_source_enable <= 1'b0;
      pdo_externally_powered <= 1'b0;
      role_swap_accept <= 1'b0;
    end else begin
      bus_bleed_drive <= (bleed_st == BLEED_ACTIVE) && !at_thresh;
      // Role bit alone decides upstream use, so micro-A after a swap counts too
      upstream_keep_connected <= ctrl[CTRL_UFP] &&
        (in_range || ctrl[CTRL_SWAP] || bleed_st == BLEED_ACTIVE);
      // Indicator is the plug sense inverted: low means a micro-A plug
      id_plug_indicator <= !plug_s;
      // Dropped in any control write so a new contract never overlaps emulation
      charger_emulation_enable <= vbus_source_enable && !ctrl[CTRL_CONTRACT] &&
        (dest == VSAFE5_CODE) && !wr_acc;
      // Cold socket: sourcing waits for a qualified insertion
      vbus_source_enable <= ctrl[CTRL_PROVIDER] && ctrl[CTRL_SRC_REQ] &&
        !ins_n_s && startup_done;
      // The flag only matters in advertised source capabilities
      pdo_externally_powered <= ctrl[CTRL_PROVIDER] && ext_s;
      // Prefer being the source with wall power, the sink without it
      role_swap_accept <= ctrl[CTRL_PROVIDER] ? !ext_s : ext_s;
    end
  end

  // Millisecond enable from the pclk divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  // Decoded from the count, so the enable lasts exactly one pclk
  assign tick = tick_cnt == 16'(TICK_CYCLES - 1);

  // Dead-battery period and pulse; bus voltage resets both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt <= 16'h0000;
      pulse_cnt <= 16'h0000;
    end else if (vbus_present) begin
      period_cnt <= 16'h0000;
      pulse_cnt <= 16'h0000;
    // Counting only on ticks keeps the ten second period inside 16 bits
    end else if (tick) begin
      if (period_cnt == 16'(DB_PERIOD_TICKS - 1)) begin
        period_cnt <= 16'h0000;
        pulse_cnt <= db_pw;
      end else begin
        period_cnt <= period_cnt + 16'h0001;
        if (pulse_cnt != 16'h0000) begin
          pulse_cnt <= pulse_cnt - 16'h0001;
        end
      end
    end
  end

  // Pulse output registered; a zero width disables pulsing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_battery_supply_enable <= 1'b0;
    end else begin
      dead_battery_supply_enable <= !vbus_present && (pulse_cnt != 16'h0000);
    end
  end

  // Status word shows the block's own state
  always_comb begin
    stat = 32'h0000_0000;
    stat[ST_BLEED] = bus_bleed_drive;
    stat[ST_KEEP] = upstream_keep_connected;
    stat[ST_ID] = id_plug_indicator;
    stat[ST_EMU] = charger_emulation_enable;
    stat[ST_DB] = dead_battery_supply_enable;
    stat[ST_SRC] = vbus_source_enable;
    stat[ST_EPWR] = pdo_externally_powered;
    stat[ST_SWAP_OK] = role_swap_accept;
    stat[ST_STARTUP_DONE] = startup_done;
    stat[ST_VPRES] = vbus_present;
    stat[ST_BUS_VOLTAGE_MONITOR_LSB +: BUS_VOLTAGE_MONITOR_W] = bus_voltage_monitor;
  end

  // All checks run on pclk and sleep through reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bleed_go;
    bleed_go && !at_thresh && bleed_st == BLEED_IDLE;
  endsequence
  sequence s_bleed_runs;
    bleed_st == BLEED_ACTIVE ##1 bus_bleed_drive || at_thresh;
  endsequence

  AST_BLEED_START: assert property (s_bleed_go |=> s_bleed_runs)
    else $error("bleed did not start");
  AST_BLEED_RELEASE: assert property (at_thresh |=> !bus_bleed_drive)
    else $error("bleed held past threshold");
  AST_KEEP_VALID: assert property (ctrl[CTRL_UFP] && in_range |=> upstream_keep_connected)
    else $error("keep-connected low in valid range");
  AST_KEEP_SWAP: assert property (ctrl[CTRL_UFP] && ctrl[CTRL_SWAP] |=> upstream_keep_connected)
    else $error("keep-connected dropped during swap");
  AST_KEEP_ROLE: assert property (!ctrl[CTRL_UFP] |=> !upstream_keep_connected)
    else $error("keep-connected outside upstream role");
  AST_ID_PLUG: assert property ($rose(plug_s) |=> !id_plug_indicator)
    else $error("id indicator not low with plug");
  AST_EMU_ON: assert property (vbus_source_enable && !ctrl[CTRL_CONTRACT] &&
    dest == VSAFE5_CODE && !wr_acc |=> charger_emulation_enable)
    else $error("emulation not enabled at five volts");
  AST_EMU_OFF: assert property (ctrl[CTRL_CONTRACT] |=> !charger_emulation_enable)
    else $error("emulation on under contract");
  AST_STARTUP: assert property (!ins_n_s |=> startup_done)
    else $error("insertion did not end startup");
  AST_COLD: assert property (ins_n_s |=> !vbus_source_enable)
    else $error("sourcing without insertion");
  AST_DB_STOP: assert property (vbus_present |=> !dead_battery_supply_enable [*2])
    else $error("dead-battery pulse with bus voltage");
  AST_DB_FIRE: assert property (tick && !vbus_present && db_pw != 16'h0000 &&
    period_cnt == 16'(DB_PERIOD_TICKS - 1) ##1 !vbus_present |=> dead_battery_supply_enable)
    else $error("dead-battery pulse missing");
  AST_EPWR: assert property (ctrl[CTRL_PROVIDER] && ext_s |=> pdo_externally_powered)
    else $error("externally powered flag not set");
  AST_SWAP_PREF: assert property (ctrl[CTRL_PROVIDER] && ext_s |=> !role_swap_accept)
    else $error("swap accepted while wall powered");

  // Quieter paths: the clear, the sink side and the zero width are reached rarely
  sequence s_plug_seen;
    ins_n_s ##1 !ins_n_s;
  endsequence
  sequence s_sw_clear;
    ins_n_s && wr_acc && paddr == OFS_CTRL && pwdata[CTRL_STARTUP_CLR];
  endsequence

  AST_BLEED_IDLE: assert property (bleed_st == BLEED_IDLE |=> !bus_bleed_drive)
    else $error("bleed drive without a sequence");
  AST_KEEP_BLEED: assert property (ctrl[CTRL_UFP] && bleed_st == BLEED_ACTIVE |=>
    upstream_keep_connected)
    else $error("keep-connected dropped during bleed");
  AST_ID_CLEAR: assert property ($fell(plug_s) |=> id_plug_indicator)
    else $error("id indicator not high without plug");
  AST_EMU_WRITE: assert property (wr_acc |=> !charger_emulation_enable)
    else $error("emulation held through control write");
  AST_PLUG_SEEN: assert property (s_plug_seen |=> startup_done)
    else $error("insertion edge did not end startup");
  AST_STARTUP_CLR: assert property (s_sw_clear |=> !startup_done)
    else $error("startup flag not cleared");
  // Sourcing implies the insertion flag, whatever order software writes in
  AST_SRC_QUAL: assert property (vbus_source_enable |-> startup_done)
    else $error("sourcing before qualified insertion");
  AST_EPWR_SINK: assert property (!ctrl[CTRL_PROVIDER] |=> !pdo_externally_powered)
    else $error("externally powered flag as sink");
  AST_SWAP_SINK: assert property (!ctrl[CTRL_PROVIDER] && ext_s |=> role_swap_accept)
    else $error("sink refused swap while wall powered");
  // Pulse may only follow a cycle with no bus voltage; zero width stays silent
  AST_DB_VBUS: assert property (dead_battery_supply_enable |-> !$past(vbus_present))
    else $error("dead-battery pulse after bus voltage");
  AST_DB_ZERO: assert property (db_pw == 16'h0000 && pulse_cnt == 16'h0000 |=>
    !dead_battery_supply_enable)
    else $error("dead-battery pulse with zero width");
endmodule : pdps_top

// [testbench/pd_port_power_path_signals_tb_top.sv]
`timescale 1ns/10ps
module pd_port_power_path_signals_tb_top;
  import pdps_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, load = 1'b0;
  logic [9:0] mon;
  logic [9:0] code = 10'h000;
  logic ins_n = 1'b1;
  logic plug = 1'b0;
  logic ext = 1'b0;
  logic bleed, keep, idi, emu, db, src, epwr, swp;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n, m;
  logic [9:0] kc [5] = '{10'h0C8, 10'h0B3, 10'h0B4, 10'h370, 10'h371};
  logic ke [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #12.5 pclk = ~pclk;

  pdps_top #(.TICK_CYCLES(4), .DB_PERIOD_TICKS(5)) pdps_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_voltage_monitor(mon), .insertion_detect_n(ins_n), .micro_a_plug_present(plug),
    .external_supply_present(ext), .bus_bleed_drive(bleed), .upstream_keep_connected(keep),
    .id_plug_indicator(idi), .charger_emulation_enable(emu),
    .dead_battery_supply_enable(db), .vbus_source_enable(src),
    .pdo_externally_powered(epwr), .role_swap_accept(swp));
  pdps_port_model pdps_port_model_i (.pclk(pclk), .presetn(presetn), .load(load),
    .preset_code(code), .bus_bleed_drive(bleed), .bus_voltage_monitor(mon));

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp, input string s);
    chk({31'h0, got}, {31'h0, exp}, s);
  endtask : chkb

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask : wt

  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setv(input logic [9:0] c);
    @(posedge pclk);
    code <= c;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
  endtask : setv

  // Sample on the falling edge so the design's updates have landed
  task automatic until_db(input logic v, output int k);
    k = 0;
    while (db !== v && k < 80) begin
      @(negedge pclk);
      k++;
    end
  endtask : until_db

  // Bleed from 480 codes; release must land at or just under the threshold
  task automatic bleed_run(input int lim);
    setv(10'h1E0);
    apb(1'b1, OFS_CTRL, 32'h0000_0020);
    n = 0;
    while (bleed !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    chkb(bleed, 1'b1, "bleed on");
    while (bleed === 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chkb(mon <= lim && mon >= lim - 24, 1'b1, "bleed release");
  endtask : bleed_run

  initial begin
    wt(3);
    chkb(idi, 1'b1, "id in reset");
    chkb(bleed | keep | emu | db | src | epwr, 1'b0, "outputs in reset");
    presetn <= 1'b1;
    wt(3);
    apb(1'b0, OFS_BLEED, 32'h0);
    chk(rd, 32'h005A_00C8, "bleed reg reset");
    apb(1'b0, OFS_DBPW, 32'h0);
    chk(rd, 32'h0000_0064, "width reg reset");
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chkb(er, 1'b1, "unmapped write");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[31:1], ~er}, 32'h0, "unmapped read");
    $display("test registers done");
    plug <= 1'b1;
    wt(5);
    chkb(idi, 1'b0, "id plug in");
    plug <= 1'b0;
    wt(5);
    chkb(idi, 1'b1, "id plug out");
    $display("test id done");
    apb(1'b1, OFS_CTRL, 32'h0000_0012);
    wt(5);
    chkb(src, 1'b0, "source cold socket");
    apb(1'b0, OFS_STAT, 32'h0);
    chkb(rd[ST_STARTUP_DONE], 1'b0, "startup held");
    ins_n <= 1'b0;
    wt(6);
    chkb(src, 1'b1, "source after insert");
    chkb(emu, 1'b1, "emulation no contract");
    apb(1'b0, OFS_STAT, 32'h0);
    chkb(rd[ST_STARTUP_DONE], 1'b1, "startup left");
    apb(1'b1, OFS_CTRL, 32'h0000_0016);
    wt(3);
    chkb(emu, 1'b0, "emulation contract");
    apb(1'b1, OFS_CTRL, 32'h0000_0012);
    wt(3);
    chkb(emu, 1'b1, "emulation again");
    ins_n <= 1'b1;
    wt(5);
    chkb(src, 1'b0, "source plug out");
    apb(1'b1, OFS_CTRL, 32'h0000_0040);
    apb(1'b0, OFS_STAT, 32'h0);
    chkb(rd[ST_STARTUP_DONE], 1'b0, "startup cleared");
    $display("test source done");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      setv(kc[i]);
      wt(4);
      chkb(keep, ke[i], "keep range");
    end
    setv(10'h0C8);
    apb(1'b1, OFS_CTRL, 32'h0000_0009);
    setv(10'h064);
    wt(4);
    chkb(keep, 1'b1, "keep through swap");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    wt(4);
    chkb(keep, 1'b0, "keep low after swap");
    plug <= 1'b1;
    setv(10'h0C8);
    wt(5);
    chkb(keep, 1'b1, "keep micro-A");
    plug <= 1'b0;
    $display("test keep done");
    apb(1'b1, OFS_CTRL, 32'h0);
    bleed_run(180);
    apb(1'b1, OFS_BLEED, 32'h0032_00C8);
    bleed_run(100);
    $display("test bleed done");
    ext <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    wt(5);
    chkb(epwr, 1'b1, "ext flag");
    chkb(swp, 1'b0, "provider ext");
    apb(1'b1, OFS_CTRL, 32'h0);
    wt(3);
    chkb(swp, 1'b1, "sink ext");
    ext <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    wt(5);
    chkb(epwr, 1'b0, "no ext flag");
    chkb(swp, 1'b1, "provider no ext");
    $display("test ext done");
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DBPW, 32'h0000_0002);
    setv(10'h000);
    until_db(1'b1, n);
    until_db(1'b0, n);
    until_db(1'b1, m);
    chk(32'(n), 32'd8, "pulse width");
    chk(32'(n + m), 32'd20, "pulse period");
    setv(10'h0C8);
    wt(10);
    until_db(1'b1, n);
    chk(32'(n), 32'd80, "no pulse on bus");
    apb(1'b1, OFS_DBPW, 32'h0);
    setv(10'h000);
    until_db(1'b1, n);
    chk(32'(n), 32'd80, "zero width");
    $display("test dead battery done");
    give_verdict();
  end
endmodule : pd_port_power_path_signals_tb_top

// [testbench/pdps_port_model.sv]
`timescale 1ns/10ps
// Port power stage: holds a preset bus level, bleeds it down while the NFET conducts
module pdps_port_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [9:0] preset_code,
  input wire logic bus_bleed_drive,
  output logic [9:0] bus_voltage_monitor
);
  // Fixed slope stands in for the RC decay; a steep one keeps runs short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_voltage_monitor <= 10'h000;
    end else if (load) begin
      bus_voltage_monitor <= preset_code;
    end else if (bus_bleed_drive && bus_voltage_monitor >= 10'h008) begin
      bus_voltage_monitor <= bus_voltage_monitor - 10'h008;
    end
  end
endmodule : pdps_port_model
